// ### include/fpeg_pkg.sv
// package: register map, key codes, lock states and carriers
package fpeg_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] FPEG_PSC_ADDR   = 8'h8f;
  localparam logic [7:0] FPEG_PSC_PAGE   = 8'h00;
  localparam logic [7:0] FPEG_KEY_ADDR   = 8'hb7;
  localparam logic [7:0] FPEG_PSC_RESET  = 8'h00;
  localparam logic [7:0] FPEG_KEY_RESET  = 8'h00;
  localparam int         FPEG_WE_BIT     = 0;
  localparam int         FPEG_EE_BIT     = 1;

  // ----------------------------------------------------------------
  // unlock sequence
  // ----------------------------------------------------------------
  localparam logic [7:0] FPEG_KEY_FIRST  = 8'ha5;
  localparam logic [7:0] FPEG_KEY_SECOND = 8'hf1;

  // lock state readout codes
  localparam logic [1:0] FPEG_RD_LOCKED  = 2'h0;
  localparam logic [1:0] FPEG_RD_FIRST   = 2'h1;
  localparam logic [1:0] FPEG_RD_OPEN    = 2'h2;
  localparam logic [1:0] FPEG_RD_DEAD    = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPEG_LOCKED,
    FPEG_FIRST_KEY,
    FPEG_UNLOCKED,
    FPEG_DISABLED
  } fpeg_lock_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] page;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fpeg_sfr_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  data;
  } fpeg_mem_t;

  typedef struct packed {
    logic        we;
    logic        ee;
    fpeg_lock_t  lock;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        fl_wr;
    logic        fl_er;
    fpeg_mem_t   fl;
    fpeg_mem_t   xram;
  } fpeg_state_t;

endpackage

// ### rtl/fpeg_gate.sv
// flash program/erase gate: control register, key lock, move-write steering
`timescale 1ns/1ps

module fpeg_gate (
  // clock and reset
  input  wire logic               SYS_CLK_IN,
  input  wire logic               RESET_IN,
  // special-function register port
  input  wire fpeg_pkg::fpeg_sfr_t SFR_IN,
  output logic [7:0]              SFR_RDATA_OUT,
  output logic                    SFR_RVALID_OUT,
  // external move write from the core
  input  wire fpeg_pkg::fpeg_mem_t MOVE_IN,
  // flash array side
  output logic                    FLASH_WRITE_OUT,
  output logic                    FLASH_ERASE_OUT,
  output fpeg_pkg::fpeg_mem_t     FLASH_OUT,
  // external data memory side
  output fpeg_pkg::fpeg_mem_t     XRAM_OUT
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic hit_psc(input fpeg_pkg::fpeg_sfr_t s);
    hit_psc = (s.addr == fpeg_pkg::FPEG_PSC_ADDR) &&
              (s.page == fpeg_pkg::FPEG_PSC_PAGE);
  endfunction

  function automatic logic hit_key(input fpeg_pkg::fpeg_sfr_t s);
    hit_key = (s.addr == fpeg_pkg::FPEG_KEY_ADDR);
  endfunction

  function automatic logic [1:0] lock_code(input fpeg_pkg::fpeg_lock_t l);
    case (l)
      fpeg_pkg::FPEG_LOCKED:    lock_code = fpeg_pkg::FPEG_RD_LOCKED;
      fpeg_pkg::FPEG_FIRST_KEY: lock_code = fpeg_pkg::FPEG_RD_FIRST;
      fpeg_pkg::FPEG_UNLOCKED:  lock_code = fpeg_pkg::FPEG_RD_OPEN;
      default:                  lock_code = fpeg_pkg::FPEG_RD_DEAD;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  fpeg_pkg::fpeg_state_t st_reg;
  fpeg_pkg::fpeg_state_t st_next;
  fpeg_pkg::fpeg_lock_t  lock_mid;
  logic                  move_to_flash;

  always_comb begin
    st_next = st_reg;
    lock_mid = st_reg.lock;
    st_next.fl_wr = 1'b0;
    st_next.fl_er = 1'b0;
    st_next.fl.wr = 1'b0;
    st_next.xram.wr = 1'b0;
    st_next.rvalid = 1'b0;
    move_to_flash = MOVE_IN.wr && st_reg.we;

    // move write steering
    if (MOVE_IN.wr && !st_reg.we) begin
      st_next.xram = MOVE_IN;
    end
    if (move_to_flash) begin
      if (st_reg.lock == fpeg_pkg::FPEG_UNLOCKED) begin
        st_next.fl.wr = 1'b1;
        st_next.fl.addr = MOVE_IN.addr;
        if (st_reg.ee) begin
          st_next.fl_er = 1'b1;
          st_next.fl.data = 8'h00;
        end else begin
          st_next.fl_wr = 1'b1;
          st_next.fl.data = MOVE_IN.data;
        end
        lock_mid = fpeg_pkg::FPEG_LOCKED;
      end else begin
        lock_mid = fpeg_pkg::FPEG_DISABLED;
      end
    end

    // key sequence
    if (SFR_IN.wr && hit_key(SFR_IN)) begin
      case (lock_mid)
        fpeg_pkg::FPEG_LOCKED: begin
          if (SFR_IN.wdata == fpeg_pkg::FPEG_KEY_FIRST) begin
            lock_mid = fpeg_pkg::FPEG_FIRST_KEY;
          end else begin
            lock_mid = fpeg_pkg::FPEG_DISABLED;
          end
        end
        fpeg_pkg::FPEG_FIRST_KEY: begin
          if (SFR_IN.wdata == fpeg_pkg::FPEG_KEY_SECOND) begin
            lock_mid = fpeg_pkg::FPEG_UNLOCKED;
          end else begin
            lock_mid = fpeg_pkg::FPEG_DISABLED;
          end
        end
        default: begin
          lock_mid = fpeg_pkg::FPEG_DISABLED;
        end
      endcase
    end
    st_next.lock = lock_mid;

    // control register write, upper bits dropped
    if (SFR_IN.wr && hit_psc(SFR_IN)) begin
      st_next.we = SFR_IN.wdata[fpeg_pkg::FPEG_WE_BIT];
      st_next.ee = SFR_IN.wdata[fpeg_pkg::FPEG_EE_BIT];
    end

    // read path, pre-write values
    if (SFR_IN.rd) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = 8'h00;
      if (hit_psc(SFR_IN)) begin
        st_next.rdata[fpeg_pkg::FPEG_WE_BIT] = st_reg.we;
        st_next.rdata[fpeg_pkg::FPEG_EE_BIT] = st_reg.ee;
      end else if (hit_key(SFR_IN)) begin
        st_next.rdata[1:0] = lock_code(st_reg.lock);
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      st_reg <= '0;
      st_reg.we <= fpeg_pkg::FPEG_PSC_RESET[fpeg_pkg::FPEG_WE_BIT];
      st_reg.ee <= fpeg_pkg::FPEG_PSC_RESET[fpeg_pkg::FPEG_EE_BIT];
      st_reg.lock <= fpeg_pkg::FPEG_LOCKED;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign SFR_RDATA_OUT   = st_reg.rdata;
  assign SFR_RVALID_OUT  = st_reg.rvalid;
  assign FLASH_WRITE_OUT = st_reg.fl_wr;
  assign FLASH_ERASE_OUT = st_reg.fl_er;
  assign FLASH_OUT       = st_reg.fl;
  assign XRAM_OUT        = st_reg.xram;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_first_key;
    SFR_IN.wr && hit_key(SFR_IN) && SFR_IN.wdata == fpeg_pkg::FPEG_KEY_FIRST
      && st_reg.lock == fpeg_pkg::FPEG_LOCKED && !move_to_flash;
  endsequence

  sequence s_second_key;
    SFR_IN.wr && hit_key(SFR_IN)
      && SFR_IN.wdata == fpeg_pkg::FPEG_KEY_SECOND && !move_to_flash;
  endsequence

  sequence s_two_keys;
    s_first_key ##1 s_second_key;
  endsequence

  sequence s_flash_op;
    move_to_flash && st_reg.lock == fpeg_pkg::FPEG_UNLOCKED;
  endsequence

  AST_MOVE_BYTE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    move_to_flash && st_reg.lock == fpeg_pkg::FPEG_UNLOCKED && !st_reg.ee
      |=> FLASH_WRITE_OUT && !FLASH_ERASE_OUT && FLASH_OUT.wr
      && FLASH_OUT.addr == $past(MOVE_IN.addr)
      && FLASH_OUT.data == $past(MOVE_IN.data))
    else $error("byte write not issued");

  AST_STROBE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    s_flash_op |=> FLASH_OUT.wr && (FLASH_WRITE_OUT != FLASH_ERASE_OUT))
    else $error("flash operation strobe malformed");

  AST_NO_XRAM_WE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    MOVE_IN.wr && st_reg.we |=> !XRAM_OUT.wr)
    else $error("move write leaked to external memory");

  AST_XRAM_CAUSE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    XRAM_OUT.wr |-> $past(MOVE_IN.wr) && !$past(st_reg.we))
    else $error("external memory write without cause");

  AST_WE_CLEAR: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    !st_reg.we |=> !FLASH_WRITE_OUT && !FLASH_ERASE_OUT)
    else $error("flash touched with write enable clear");

  AST_ERASE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    move_to_flash && st_reg.lock == fpeg_pkg::FPEG_UNLOCKED && st_reg.ee
      |=> FLASH_ERASE_OUT && !FLASH_WRITE_OUT && FLASH_OUT.wr
      && FLASH_OUT.addr == $past(MOVE_IN.addr) && FLASH_OUT.data == 8'h00)
    else $error("page erase not issued");

  AST_EE_CLEAR: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    !st_reg.ee |=> !FLASH_ERASE_OUT)
    else $error("erase with erase enable clear");

  AST_PSC_READ: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    SFR_IN.rd && hit_psc(SFR_IN) |=> SFR_RVALID_OUT
      && SFR_RDATA_OUT[7:2] == 6'h00)
    else $error("control register upper bits not zero");

  AST_PSC_WRITE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    SFR_IN.wr && hit_psc(SFR_IN)
      |=> st_reg.we == $past(SFR_IN.wdata[fpeg_pkg::FPEG_WE_BIT])
      && st_reg.ee == $past(SFR_IN.wdata[fpeg_pkg::FPEG_EE_BIT]))
    else $error("control register write not taken");

  AST_UNLOCK: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    s_two_keys |=> st_reg.lock == fpeg_pkg::FPEG_UNLOCKED)
    else $error("key sequence did not unlock");

  AST_FLASH_CAUSE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    FLASH_WRITE_OUT || FLASH_ERASE_OUT
      |-> $past(move_to_flash)
      && $past(st_reg.lock) == fpeg_pkg::FPEG_UNLOCKED)
    else $error("flash operation without unlock");

  AST_RELOCK: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    move_to_flash && st_reg.lock == fpeg_pkg::FPEG_UNLOCKED
      && !(SFR_IN.wr && hit_key(SFR_IN))
      |=> st_reg.lock == fpeg_pkg::FPEG_LOCKED)
    else $error("gate not relocked after operation");

  AST_BAD_KEY: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    SFR_IN.wr && hit_key(SFR_IN) && st_reg.lock == fpeg_pkg::FPEG_FIRST_KEY
      && SFR_IN.wdata != fpeg_pkg::FPEG_KEY_SECOND
      |=> (st_reg.lock == fpeg_pkg::FPEG_DISABLED) [*3])
    else $error("wrong second key did not disable");

  AST_DEAD_STAYS: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    st_reg.lock == fpeg_pkg::FPEG_DISABLED
      |=> st_reg.lock == fpeg_pkg::FPEG_DISABLED && !FLASH_WRITE_OUT
      && !FLASH_ERASE_OUT)
    else $error("disabled gate reopened");

  AST_LOCKED_TRY: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    move_to_flash && st_reg.lock != fpeg_pkg::FPEG_UNLOCKED
      |=> st_reg.lock == fpeg_pkg::FPEG_DISABLED && !FLASH_WRITE_OUT
      && !FLASH_ERASE_OUT)
    else $error("locked flash attempt not punished");

  AST_FIRST_BAD: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    SFR_IN.wr && hit_key(SFR_IN) && st_reg.lock == fpeg_pkg::FPEG_LOCKED
      && SFR_IN.wdata != fpeg_pkg::FPEG_KEY_FIRST && !move_to_flash
      |=> st_reg.lock == fpeg_pkg::FPEG_DISABLED)
    else $error("bad first key did not disable");

  AST_KEY_READ: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    SFR_IN.rd && hit_key(SFR_IN) |=> SFR_RDATA_OUT[1:0]
      == lock_code($past(st_reg.lock)) && SFR_RDATA_OUT[7:2] == 6'h00)
    else $error("key register readout wrong");

  AST_RVALID_ONE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    SFR_RVALID_OUT |-> $past(SFR_IN.rd))
    else $error("read valid without read strobe");

  AST_KEY_PAGE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    SFR_IN.wr && hit_key(SFR_IN) && SFR_IN.page != fpeg_pkg::FPEG_PSC_PAGE
      && SFR_IN.wdata == fpeg_pkg::FPEG_KEY_FIRST && !move_to_flash
      && st_reg.lock == fpeg_pkg::FPEG_LOCKED
      |=> st_reg.lock == fpeg_pkg::FPEG_FIRST_KEY)
    else $error("key write off page zero not taken");

  AST_PSC_PAGE: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    SFR_IN.wr && SFR_IN.addr == fpeg_pkg::FPEG_PSC_ADDR
      && SFR_IN.page != fpeg_pkg::FPEG_PSC_PAGE
      |=> $stable(st_reg.we) && $stable(st_reg.ee))
    else $error("control register hit off page zero");

  AST_XRAM_PASS: assert property (
    @(posedge SYS_CLK_IN) disable iff (RESET_IN)
    MOVE_IN.wr && !st_reg.we |=> XRAM_OUT.wr
      && XRAM_OUT.addr == $past(MOVE_IN.addr)
      && XRAM_OUT.data == $past(MOVE_IN.data))
    else $error("move write not passed to external memory");

endmodule

// ### sim/fpeg_flash_model.sv
// flash array model: byte program only clears bits, page erase sets ones
`timescale 1ns/1ps
module fpeg_flash_model #(
  parameter int PAGE_BYTES = 256
) (
  // clock
  input  wire logic                clk_in,
  // program and erase strobes from the gate
  input  wire logic                write_in,
  input  wire logic                erase_in,
  input  wire fpeg_pkg::fpeg_mem_t fl_in,
  // backdoor read for the bench
  input  wire logic [15:0]         rd_addr_in,
  output logic [7:0]               rd_data_out
);
  logic [7:0] mem [0:65535];
  int         base;

  // array leaves the factory erased
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'hff;
  end

  always @(posedge clk_in) begin
    if (erase_in) begin
      base = int'(fl_in.addr) & ~(PAGE_BYTES - 1);
      for (int i = 0; i < PAGE_BYTES; i++) mem[base + i] <= 8'hff;
    end else if (write_in) begin
      mem[fl_in.addr] <= mem[fl_in.addr] & fl_in.data;
    end
  end

  assign rd_data_out = mem[rd_addr_in];
endmodule

// ### sim/fpeg_gate_test.sv
// self-checking bench for the flash program/erase gate
`timescale 1ns/1ps
module fpeg_gate_test;
  localparam logic [7:0] KA = fpeg_pkg::FPEG_KEY_ADDR;
  localparam logic [7:0] PA = fpeg_pkg::FPEG_PSC_ADDR;
  localparam logic [7:0] K1 = fpeg_pkg::FPEG_KEY_FIRST;
  localparam logic [7:0] K2 = fpeg_pkg::FPEG_KEY_SECOND;
  logic                SYS_CLK_IN = 1'b0;
  logic                RESET_IN   = 1'b1;
  fpeg_pkg::fpeg_sfr_t SFR_IN     = '0;
  fpeg_pkg::fpeg_mem_t MOVE_IN    = '0;
  logic [7:0]          SFR_RDATA_OUT;
  logic                SFR_RVALID_OUT;
  logic                FLASH_WRITE_OUT;
  logic                FLASH_ERASE_OUT;
  fpeg_pkg::fpeg_mem_t FLASH_OUT;
  fpeg_pkg::fpeg_mem_t XRAM_OUT;
  logic [15:0]         peek_addr = '0;
  logic [7:0]          peek_data;
  int                  err_count = 0;
  int                  checks_done = 0;
  logic [1:0]          lock;
  logic [7:0]          ctl, v, d, pg;
  logic [15:0]         a;

  always #2 SYS_CLK_IN = ~SYS_CLK_IN;

  fpeg_gate fpeg_gate_inst (.SYS_CLK_IN(SYS_CLK_IN), .RESET_IN(RESET_IN),
    .SFR_IN(SFR_IN), .SFR_RDATA_OUT(SFR_RDATA_OUT),
    .SFR_RVALID_OUT(SFR_RVALID_OUT), .MOVE_IN(MOVE_IN),
    .FLASH_WRITE_OUT(FLASH_WRITE_OUT), .FLASH_ERASE_OUT(FLASH_ERASE_OUT),
    .FLASH_OUT(FLASH_OUT), .XRAM_OUT(XRAM_OUT));
  fpeg_flash_model fpeg_flash_model_inst (.clk_in(SYS_CLK_IN),
    .write_in(FLASH_WRITE_OUT), .erase_in(FLASH_ERASE_OUT),
    .fl_in(FLASH_OUT), .rd_addr_in(peek_addr), .rd_data_out(peek_data));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic do_reset();
    RESET_IN = 1'b1;
    repeat (2) @(negedge SYS_CLK_IN);
    RESET_IN = 1'b0;
    lock = fpeg_pkg::FPEG_RD_LOCKED;
    ctl = 8'h00;
  endtask

  // one register access; a read is compared the cycle rvalid stands
  task automatic sfr(input logic w, input logic [7:0] p, input logic [7:0] ad,
                     input logic [7:0] wd, input logic [7:0] exp);
    @(negedge SYS_CLK_IN);
    SFR_IN = '{wr: w, rd: !w, page: p, addr: ad, wdata: wd};
    @(negedge SYS_CLK_IN);
    SFR_IN = '0;
    if (!w) chk({SFR_RVALID_OUT, SFR_RDATA_OUT}, {1'b1, exp});
  endtask

  function automatic logic [1:0] key_next(input logic [1:0] s,
                                          input logic [7:0] k);
    if (s == fpeg_pkg::FPEG_RD_LOCKED && k == K1)
      return fpeg_pkg::FPEG_RD_FIRST;
    if (s == fpeg_pkg::FPEG_RD_FIRST && k == K2) return fpeg_pkg::FPEG_RD_OPEN;
    return fpeg_pkg::FPEG_RD_DEAD;
  endfunction

  // key access from a random register page
  task automatic key(input logic [7:0] k);
    sfr(1'b1, 8'($urandom), KA, k, 8'h00);
    lock = key_next(lock, k);
    sfr(1'b0, 8'($urandom), KA, 8'h00, {6'h00, lock});
  endtask

  // both keys on consecutive cycles
  task automatic keys_fast();
    @(negedge SYS_CLK_IN);
    SFR_IN = '{wr: 1'b1, rd: 1'b0, page: 8'($urandom), addr: KA, wdata: K1};
    @(negedge SYS_CLK_IN);
    SFR_IN.wdata = K2;
    @(negedge SYS_CLK_IN);
    SFR_IN = '0;
    lock = key_next(key_next(lock, K1), K2);
    sfr(1'b0, 8'h00, KA, 8'h00, {6'h00, lock});
  endtask

  task automatic ctl_wr(input logic [7:0] val);
    sfr(1'b1, 8'h00, PA, val, 8'h00);
    ctl = val & 8'h03;
  endtask

  task automatic move(input logic [15:0] ad, input logic [7:0] dt);
    logic fl;
    fl = ctl[0] && lock == fpeg_pkg::FPEG_RD_OPEN;
    @(negedge SYS_CLK_IN);
    MOVE_IN = '{wr: 1'b1, addr: ad, data: dt};
    @(negedge SYS_CLK_IN);
    MOVE_IN = '0;
    chk(XRAM_OUT.wr, !ctl[0]);
    if (!ctl[0]) chk({XRAM_OUT.addr, XRAM_OUT.data}, {ad, dt});
    chk({FLASH_WRITE_OUT, FLASH_ERASE_OUT},
        {fl && !ctl[1], fl && ctl[1]});
    if (fl) chk({FLASH_OUT.wr, FLASH_OUT.addr, FLASH_OUT.data},
                {1'b1, ad, ctl[1] ? 8'h00 : dt});
    if (ctl[0]) lock = fl ? fpeg_pkg::FPEG_RD_LOCKED : fpeg_pkg::FPEG_RD_DEAD;
    sfr(1'b0, 8'h00, KA, 8'h00, {6'h00, lock});
  endtask

  task automatic peek(input logic [15:0] ad, input logic [7:0] exp);
    peek_addr = ad;
    #1;
    chk(peek_data, exp);
  endtask

  initial begin
    v = 8'($urandom(57674));
    do_reset();
    sfr(1'b0, 8'h00, PA, 8'h00, fpeg_pkg::FPEG_PSC_RESET);
    sfr(1'b0, 8'($urandom), KA, 8'h00, fpeg_pkg::FPEG_KEY_RESET);
    repeat (8) begin
      v = 8'($urandom);
      pg = 8'($urandom) | 8'h01;
      sfr(1'b1, pg, PA, 8'hff, 8'h00);
      sfr(1'b0, pg, PA, 8'h00, 8'h00);
      sfr(1'b0, 8'h00, PA, 8'h00, ctl);
      ctl_wr(v);
      sfr(1'b0, 8'h00, PA, 8'h00, {6'h00, v[1:0]});
      ctl_wr(v & 8'hfe);
      move(16'($urandom), 8'($urandom));
    end
    a = 16'($urandom);
    key(K1);
    key(K2);
    ctl_wr(8'h03);
    move(a, 8'($urandom));
    peek(a, 8'hff);
    d = 8'($urandom) & 8'h7f;
    keys_fast();
    ctl_wr(8'h01);
    move(a, d);
    peek(a, d);
    key(K1);
    key(K2);
    ctl_wr(8'h03);
    move(a ^ 16'h0001, 8'($urandom));
    peek(a, 8'hff);
    move(a + 16'h0001, 8'h00);
    key(K1);
    key(K2);
    move(a, 8'h00);
    repeat (24) begin
      do_reset();
      repeat (3) begin
        case ($urandom % 3)
          0: v = K1;
          1: v = K2;
          default: v = 8'($urandom);
        endcase
        key(v);
      end
      ctl_wr(8'h01 | (8'($urandom) & 8'h02));
      move(16'($urandom), 8'($urandom));
    end
    summarize();
  end
endmodule
